// [src/thermal_trip_pkg.sv]
/*
 * Shared constants and carrier types for the thermal trip and power status block.
 * Assumes a single 50 MHz reference clock; no software-visible registers.
 */
package thermal_trip_pkg;
   localparam int unsigned CLK_FREQ_HZ    = 50_000_000;
   localparam int unsigned VSEL_WIDTH     = 5;
   // settle time for the voltage-select outputs before power good, in ns
   localparam int unsigned VSEL_SETTLE_NS = 1000;
   localparam int unsigned VSEL_SETTLE_CYC =
      (VSEL_SETTLE_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned SETTLE_CNT_W   = 8;
   localparam logic [SETTLE_CNT_W-1:0] SETTLE_LAST = 8'(VSEL_SETTLE_CYC - 1);
   localparam logic [SETTLE_CNT_W-1:0] SETTLE_ZERO = 8'h00;
   localparam logic [VSEL_WIDTH-1:0]   VSEL_RESET  = 5'h00;

   typedef enum logic [1:0] {
      ST_RUN,
      ST_TRIPPED,
      ST_POWER_OFF
   } trip_state_t;

   // supply-side status sampled from pins
   typedef struct packed {
      logic coreOn;
      logic termOn;
   } supply_t;
endpackage

// [src/thermal_trip_power_status.sv]
/*
 * Thermal trip latch, execution halt and termination power-good signalling.
 * Assumes overtemperature and supply-present levels arrive asynchronously and
 * that the voltage-select code is a fused value from logic on ref_clk.
 */
//
// Operation
// - An overtemperature report halts execution and drives the low-active trip output.
// - The trip output stays latched until reset or loss of both supplies; halt stays until reset.
// - With no hysteresis, a reset while cool clears the trip and lets execution resume.
// - A reset while still hot releases the trip output and halt, which return three enabled clocks after reset.
// - Once both supplies are off the trip output is released.
// - Termination power good rises only after the voltage-select outputs are stable.
`timescale 1ns/1ps
module thermal_trip_power_status (
   // clock, reset, enable
   input  wire logic                                     ref_clk,
   input  wire logic                                     rst_n,
   input  wire logic                                     clkEn,
   // asynchronous pins
   input  wire logic                                     overTempIn,
   input  wire thermal_trip_pkg::supply_t                supplyIn,
   // from core logic
   input  wire logic [thermal_trip_pkg::VSEL_WIDTH-1:0]  voltageSelectIn,
   // outputs
   output logic                                          thermal_trip_out_n,
   output logic                                          haltExec,
   output logic [thermal_trip_pkg::VSEL_WIDTH-1:0]       voltage_select_code,
   output logic                                          termination_power_good
);
   logic                                 otMeta_ff;
   logic                                 otSync_ff;
   thermal_trip_pkg::supply_t            supMeta_ff;
   thermal_trip_pkg::supply_t            supSync_ff;
   thermal_trip_pkg::trip_state_t        state_ff;
   thermal_trip_pkg::trip_state_t        nxt_state;
   logic [thermal_trip_pkg::SETTLE_CNT_W-1:0] settle_ff;
   logic                                 bothOff;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         otMeta_ff  <= 1'b0;
         otSync_ff  <= 1'b0;
         supMeta_ff <= '0;
         supSync_ff <= '0;
      end else if (clkEn) begin
         otMeta_ff  <= overTempIn;
         otSync_ff  <= otMeta_ff;
         supMeta_ff <= supplyIn;
         supSync_ff <= supMeta_ff;
      end
   end

   // both rails must be gone together; one alone keeps the trip latched
   // supply sync resets to off, harmless because RUN ignores the supplies
   assign bothOff = !supSync_ff.coreOn && !supSync_ff.termOn;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         thermal_trip_pkg::ST_RUN: begin
            if (otSync_ff) begin
               nxt_state = thermal_trip_pkg::ST_TRIPPED;
            end
         end
         thermal_trip_pkg::ST_TRIPPED: begin
            if (bothOff) begin
               nxt_state = thermal_trip_pkg::ST_POWER_OFF;
            end
         end
         // stays dark until reset restarts; returning power is ignored
         thermal_trip_pkg::ST_POWER_OFF: begin
            nxt_state = thermal_trip_pkg::ST_POWER_OFF;
         end
         default: begin
            nxt_state = thermal_trip_pkg::ST_TRIPPED;
         end
      endcase
   end

   // reset clears the trip when cool; re-trips when hot
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_ff <= thermal_trip_pkg::ST_RUN;
      end else if (clkEn) begin
         state_ff <= nxt_state;
      end
   end

   // release trip after both supplies off
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         thermal_trip_out_n <= 1'b1;
         haltExec           <= 1'b0;
      end else if (clkEn) begin
         thermal_trip_out_n <= !(nxt_state == thermal_trip_pkg::ST_TRIPPED);
         haltExec           <= nxt_state != thermal_trip_pkg::ST_RUN;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         settle_ff              <= thermal_trip_pkg::SETTLE_ZERO;
         voltage_select_code    <= thermal_trip_pkg::VSEL_RESET;
         termination_power_good <= 1'b0;
      end else if (clkEn) begin
         voltage_select_code <= voltageSelectIn;
         if (voltageSelectIn != voltage_select_code) begin
            // any change restarts settling, so the regulator never sees a moving code
            settle_ff              <= thermal_trip_pkg::SETTLE_ZERO;
            termination_power_good <= 1'b0;
         // count saturates at the last value until the code moves
         end else if (settle_ff == thermal_trip_pkg::SETTLE_LAST) begin
            termination_power_good <= 1'b1;
         end else begin
            settle_ff <= settle_ff + 8'h01;
         end
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   property p_trip_sets;
      clkEn && otSync_ff && state_ff == thermal_trip_pkg::ST_RUN |=>
         !thermal_trip_out_n && haltExec;
   endproperty
   a_trip_sets: assert property (p_trip_sets) else $error("trip not raised");

   property p_trip_holds;
      !thermal_trip_out_n && !(bothOff && clkEn) |=> !thermal_trip_out_n;
   endproperty
   a_trip_holds: assert property (p_trip_holds) else $error("trip dropped early");

   property p_hot_after_reset;
      $rose(rst_n) ##0 (overTempIn && clkEn) [*3] |=> !thermal_trip_out_n;
   endproperty
   a_hot_after_reset: assert property (p_hot_after_reset) else $error("hot reset not tripped");

   property p_cool_runs;
      state_ff == thermal_trip_pkg::ST_RUN |-> !haltExec && thermal_trip_out_n;
   endproperty
   a_cool_runs: assert property (p_cool_runs) else $error("halted while running");

   property p_release;
      clkEn && bothOff && state_ff == thermal_trip_pkg::ST_TRIPPED |=>
         thermal_trip_out_n && haltExec;
   endproperty
   a_release: assert property (p_release) else $error("trip not released");

   property p_sync_delay;
      clkEn && overTempIn && state_ff == thermal_trip_pkg::ST_RUN ##1 clkEn ##1 clkEn |=>
         haltExec;
   endproperty
   a_sync_delay: assert property (p_sync_delay) else $error("sync latency wrong");

   property p_pg_stable;
      termination_power_good |-> $stable(voltage_select_code);
   endproperty
   a_pg_stable: assert property (p_pg_stable) else $error("code moved under good");

   property p_pg_late;
      $rose(termination_power_good) |->
         $past(voltageSelectIn) == voltage_select_code && settle_ff == thermal_trip_pkg::SETTLE_LAST;
   endproperty
   a_pg_late: assert property (p_pg_late) else $error("power good too early");

   property p_trip_means_halt;
      !thermal_trip_out_n |-> haltExec;
   endproperty
   a_trip_means_halt: assert property (p_trip_means_halt) else $error("trip without halt");

   // a hot input needs three edges to reach the pin
   property p_no_fast_trip;
      thermal_trip_out_n && !overTempIn && !otMeta_ff && !otSync_ff |=>
         thermal_trip_out_n [*3];
   endproperty
   a_no_fast_trip: assert property (p_no_fast_trip) else $error("trip bypassed sync");

   property p_off_released;
      state_ff == thermal_trip_pkg::ST_POWER_OFF |-> thermal_trip_out_n && haltExec;
   endproperty
   a_off_released: assert property (p_off_released) else $error("trip held after power off");

   property p_pg_drops;
      clkEn && voltageSelectIn != voltage_select_code |=> !termination_power_good;
   endproperty
   a_pg_drops: assert property (p_pg_drops) else $error("good kept over a new code");

   property p_pg_settled;
      termination_power_good |-> settle_ff == thermal_trip_pkg::SETTLE_LAST;
   endproperty
   a_pg_settled: assert property (p_pg_settled) else $error("good before full settle");

   property p_reset_idle;
      $rose(rst_n) |-> thermal_trip_out_n && !haltExec && !termination_power_good;
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");

   // a low enable freezes every output
   property p_enable_freezes;
      !clkEn |=> $stable(thermal_trip_out_n) && $stable(haltExec) &&
         $stable(termination_power_good) && $stable(voltage_select_code);
   endproperty
   a_enable_freezes: assert property (p_enable_freezes) else $error("outputs moved while frozen");

   c_trip: cover property (!thermal_trip_out_n);
   c_release: cover property (state_ff == thermal_trip_pkg::ST_POWER_OFF);
   c_pg: cover property ($rose(termination_power_good));
   c_hot_reset: cover property ($rose(rst_n) ##3 !thermal_trip_out_n);
   c_pg_drop: cover property ($fell(termination_power_good));
endmodule

// [tb/power_ctrl_model.sv]
/* System power control and regulator model for the thermal trip block.
   Assumes the block's outputs change on ref_clk. */
`timescale 1ns/1ps
module power_ctrl_model (
   // clock, reset
   input  wire logic                                   ref_clk,
   input  wire logic                                   rst_n,
   // from the block, plus the off delay from the bench
   input  wire logic                                   thermal_trip_out_n,
   input  wire logic                                   termination_power_good,
   input  wire logic [thermal_trip_pkg::VSEL_WIDTH-1:0] voltage_select_code,
   input  wire logic [31:0]                            offDelay,
   // to the block and the board
   output thermal_trip_pkg::supply_t                   supplyIn = 2'h3,
   output logic [thermal_trip_pkg::VSEL_WIDTH-1:0]     deliveredCode,
   output logic                                        tapRst_n
);
   int waitCnt = 0;
   assign tapRst_n = rst_n;
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         supplyIn <= 2'h3;
         waitCnt  <= 0;
      end else if (!thermal_trip_out_n) begin
         waitCnt <= waitCnt + 1;
         // no re-power after release; only reset restores
         if (waitCnt >= offDelay)
            supplyIn <= 2'h0;
      end
   end
   always @(posedge ref_clk) begin
      if (termination_power_good)
         deliveredCode <= voltage_select_code;
   end
endmodule

// [tb/test_thermal_trip_power_status.sv]
/* Self-checking bench for the thermal trip block.
   Assumes the power control model on the supply pins. */
`timescale 1ns/1ps
module test_thermal_trip_power_status;
   typedef logic [thermal_trip_pkg::VSEL_WIDTH-1:0] code_t;
   logic ref_clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, overTempIn = 1'b0;
   logic tripN, halt, pg;
   code_t selIn = 5'h00, selOut, delivered;
   thermal_trip_pkg::supply_t supplyIn;
   int offDelay = 20, bad_count = 0, comparisons = 0, cycles = 0, n;
   typedef struct packed {
      code_t sel;
      code_t exp;
   } row_t;
   // select input beside the code the regulator should end up with
   row_t rows [4] = '{'{5'h15, 5'h15}, '{5'h0A, 5'h0A}, '{5'h1F, 5'h1F}, '{5'h01, 5'h01}};
   thermal_trip_power_status i_thermal_trip_power_status (.ref_clk(ref_clk), .rst_n(rst_n),
      .clkEn(clkEn), .overTempIn(overTempIn), .supplyIn(supplyIn), .voltageSelectIn(selIn),
      .thermal_trip_out_n(tripN), .haltExec(halt), .voltage_select_code(selOut),
      .termination_power_good(pg));
   power_ctrl_model i_power_ctrl_model (.ref_clk(ref_clk), .rst_n(rst_n),
      .thermal_trip_out_n(tripN), .termination_power_good(pg), .voltage_select_code(selOut),
      .offDelay(offDelay), .supplyIn(supplyIn), .deliveredCode(delivered), .tapRst_n());
   initial begin
      forever #10 ref_clk = ~ref_clk;
   end
   task step(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask
   task check_bit(input logic got, input logic exp, input string what);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask
   task check_code(input code_t got, input code_t exp, input string what);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask
   task reset_for(input int k);
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (k) @(posedge ref_clk);
      rst_n <= 1'b1;
      #1;
   endtask
   task wrap_up();
      $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // long enough for every test with margin
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 4000) begin
         bad_count++;
         $display("unexpected at %0t: run too long", $time);
         wrap_up();
      end
   end
   initial begin
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      #1;
      check_bit(tripN, 1'b1, "trip after reset");
      check_bit(halt, 1'b0, "halt after reset");
      $display("test reset done");
      foreach (rows[i]) begin
         @(posedge ref_clk);
         selIn <= rows[i].sel;
         step(2);
         check_code(selOut, rows[i].exp, "select copy");
         check_bit(pg, 1'b0, "good before settle");
         for (n = 0; n < 80 && pg !== 1'b1; n++) step(1);
         check_bit(pg, 1'b1, "good after settle");
         check_bit(n == thermal_trip_pkg::SETTLE_LAST, 1'b1, "settle time");
         step(2);
         check_code(delivered, rows[i].exp, "regulator code");
      end
      $display("test power good done");
      @(posedge ref_clk);
      overTempIn <= 1'b1;
      clkEn <= 1'b0;
      step(6);
      check_bit(tripN, 1'b1, "frozen by enable");
      @(posedge ref_clk);
      clkEn <= 1'b1;
      step(2);
      check_bit(tripN, 1'b1, "trip too early");
      step(1);
      check_bit(tripN, 1'b0, "trip late");
      check_bit(halt, 1'b1, "halt late");
      @(posedge ref_clk);
      overTempIn <= 1'b0;
      step(10);
      check_bit(tripN, 1'b0, "trip not held");
      for (n = 0; n < 60 && tripN !== 1'b1; n++) step(1);
      check_bit(tripN, 1'b1, "trip not released");
      check_bit(halt, 1'b1, "halt dropped");
      $display("test trip done");
      @(posedge ref_clk);
      offDelay <= 2;
      overTempIn <= 1'b1;
      reset_for(3);
      check_bit(tripN, 1'b1, "reset value");
      check_bit(pg, 1'b0, "good cleared by reset");
      check_code(selOut, thermal_trip_pkg::VSEL_RESET, "code cleared by reset");
      step(3);
      check_bit(tripN, 1'b0, "hot reset trip");
      check_bit(halt, 1'b1, "hot reset halt");
      @(posedge ref_clk);
      overTempIn <= 1'b0;
      reset_for(3);
      step(5);
      check_bit(tripN, 1'b1, "cool reset trip");
      check_bit(halt, 1'b0, "cool reset halt");
      $display("test hot reset done");
      wrap_up();
   end
endmodule
